// ===== hw/bsis_pkg.sv
// Shared constants and types for the bit stream input sampler and its source.
package bsis_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int AUX_BAUD = 115_200;
    localparam int BIT_CYCLES = CLK_HZ / AUX_BAUD;
    localparam int HALF_BIT_CYCLES = BIT_CYCLES / 2;
    localparam int MON_MS = 10;
    localparam int MON_CYCLES = CLK_HZ / 1000 * MON_MS;
    localparam int SECOND_BASE = 2_000_000;
    localparam int LOST_CYCLES = 64;
    localparam int REF_HALF = 4;
    localparam int AUX_MAX_BYTES = 2048;
    localparam int NSTREAM = 32;
    localparam logic [2:0] FREQ_MAX = 3'h6;

    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_ACTIVE = 4'h1;
    localparam logic [3:0] REG_SET_SEC = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;
    localparam logic [3:0] REG_MASK = 4'h4;
    localparam logic [3:0] REG_OBS_SEC = 4'h5;
    localparam logic [3:0] REG_OBS_CYC = 4'h6;
    localparam logic [3:0] REG_AUX_BYTE = 4'h7;

    localparam int CTRL_FREQ_LSB = 0;
    localparam int CTRL_RATE_LSB = 3;
    localparam int CTRL_USE_ALT = 6;
    localparam int CTRL_AUTO = 7;
    localparam int CTRL_SOFT_RST = 8;
    localparam int CTRL_ARM = 9;

    localparam int ST_TICK = 0;
    localparam int ST_SET = 1;
    localparam int ST_BYTE = 2;
    localparam int ST_OVF = 3;
    localparam int ST_LOST = 4;
    localparam int ST_CFG = 5;
    localparam int ST_W = 6;

    localparam logic [31:0] ACTIVE_RST = 32'h0000_0001;

    typedef enum logic [1:0] {
        UART_IDLE = 2'h0,
        UART_START = 2'h1,
        UART_DATA = 2'h3,
        UART_STOP = 2'h2
    } bsis_uart_t;
endpackage

// ===== hw/bsis_link_if.sv
// Link between the acquisition source and the input sampler.
`timescale 1ns/1ns
interface bsis_link_if;
    logic ref_clk;
    logic second_tick;
    logic alternate_second_tick;
    logic [31:0] input_bit_stream;
    logic aux_serial_in;

    modport dev (
        input ref_clk,
        input second_tick,
        input alternate_second_tick,
        input input_bit_stream,
        input aux_serial_in
    );

    modport acq (
        output ref_clk,
        output second_tick,
        output alternate_second_tick,
        output input_bit_stream,
        output aux_serial_in
    );
endinterface

// ===== hw/bsis_acquisition_source.sv
// Acquisition side end: drives reference clock, streams, ticks and aux serial.
`timescale 1ns/1ns
module bsis_acquisition_source (
    input wire logic clk,
    input wire logic srst,
    bsis_link_if.acq link,
    input wire logic [31:0] streams_in,
    input wire logic tick_req,
    input wire logic alt_tick_in,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic data_taken
);
    typedef struct packed {
        logic [2:0] div_cnt;
        logic ref_clk;
        logic [31:0] bs;
        logic tick;
        logic tick_pend;
        logic alt;
        bsis_pkg::bsis_uart_t tx_st;
        logic [8:0] tx_cnt;
        logic [2:0] tx_bit;
        logic [7:0] tx_sh;
        logic line;
        logic [11:0] byte_cnt;
        logic taken;
    } bsis_src_t;

    bsis_src_t r;
    bsis_src_t next_r;

    always_comb
    begin
        logic fall;
        fall = 1'b0;
        next_r = r;
        next_r.taken = 1'b0;
        next_r.alt = alt_tick_in;
        if (tick_req)
        begin
            next_r.tick_pend = 1'b1;
        end
        // The reference clock runs without a break from reset onward.
        if (r.div_cnt == 3'(bsis_pkg::REF_HALF - 1))
        begin
            next_r.div_cnt = 3'h0;
            next_r.ref_clk = ~r.ref_clk;
            fall = r.ref_clk;
        end
        else
        begin
            next_r.div_cnt = r.div_cnt + 3'h1;
        end
        // Data change on the falling edge so the sampler sees them settled at rising.
        if (fall)
        begin
            next_r.bs = streams_in;
            next_r.taken = 1'b1;
            next_r.tick = r.tick_pend | tick_req;
            next_r.tick_pend = 1'b0;
            if (r.tick_pend | tick_req)
            begin
                next_r.byte_cnt = 12'h0;
            end
        end
        case (r.tx_st)
            bsis_pkg::UART_IDLE:
            begin
                next_r.line = 1'b1;
                if (tx_valid && tx_ready)
                begin
                    next_r.tx_sh = tx_data;
                    next_r.tx_st = bsis_pkg::UART_START;
                    next_r.tx_cnt = 9'h0;
                    next_r.line = 1'b0;
                    next_r.byte_cnt = r.byte_cnt + 12'h1;
                end
            end
            bsis_pkg::UART_START, bsis_pkg::UART_DATA, bsis_pkg::UART_STOP:
            begin
                if (r.tx_cnt == 9'(bsis_pkg::BIT_CYCLES - 1))
                begin
                    next_r.tx_cnt = 9'h0;
                    if (r.tx_st == bsis_pkg::UART_START)
                    begin
                        next_r.tx_st = bsis_pkg::UART_DATA;
                        next_r.tx_bit = 3'h0;
                        next_r.line = r.tx_sh[0];
                    end
                    else if (r.tx_st == bsis_pkg::UART_DATA && r.tx_bit != 3'h7)
                    begin
                        next_r.tx_bit = r.tx_bit + 3'h1;
                        next_r.tx_sh = {1'b0, r.tx_sh[7:1]};
                        next_r.line = r.tx_sh[1];
                    end
                    else if (r.tx_st == bsis_pkg::UART_DATA)
                    begin
                        next_r.tx_st = bsis_pkg::UART_STOP;
                        next_r.line = 1'b1;
                    end
                    else
                    begin
                        next_r.tx_st = bsis_pkg::UART_IDLE;
                    end
                end
                else
                begin
                    next_r.tx_cnt = r.tx_cnt + 9'h1;
                end
            end
            default:
            begin
                next_r.tx_st = bsis_pkg::UART_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            r <= '0;
            r.line <= 1'b1;
        end
        else
        begin
            r <= next_r;
        end
    end

    // The byte budget per tick keeps the sampler's overflow flag quiet.
    assign tx_ready = (r.tx_st == bsis_pkg::UART_IDLE) &&
                      (r.byte_cnt < 12'(bsis_pkg::AUX_MAX_BYTES));
    assign data_taken = r.taken;
    assign link.ref_clk = r.ref_clk;
    assign link.second_tick = r.tick;
    assign link.alternate_second_tick = r.alt;
    assign link.input_bit_stream = r.bs;
    assign link.aux_serial_in = r.line;
endmodule

// ===== hw/bsis_acquisition_input_module.sv
// Input sampler: stream sampling, observe time clock, aux serial and registers.
`timescale 1ns/1ns
module bsis_acquisition_input_module #(
    parameter int MON_CYCLES_P = bsis_pkg::MON_CYCLES,
    parameter int SECOND_BASE_P = bsis_pkg::SECOND_BASE
) (
    input wire logic clk,
    input wire logic srst,
    bsis_link_if.dev link,
    input wire logic [3:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rd_data,
    output logic [31:0] sample_data,
    output logic sample_valid,
    output logic sample_second_tick_sample,
    output logic irq,
    output logic observe_time_monitor
);
    typedef struct packed {
        logic ref_s1;
        logic ref_s2;
        logic ref_s3;
        logic tick_s1;
        logic tick_s2;
        logic tick_prev;
        logic alt_s1;
        logic alt_s2;
        logic alt_s3;
        logic aux_s1;
        logic aux_s2;
        logic [31:0] bs_s1;
        logic [31:0] bs_s2;
        logic [2:0] freq;
        logic [2:0] rate_k;
        logic use_alt;
        logic auto_upd;
        logic [31:0] active;
        logic [31:0] set_sec;
        logic [5:0] status;
        logic [5:0] mask;
        logic armed;
        logic clk_set;
        logic alt_pend;
        logic [31:0] obs_sec;
        logic [31:0] obs_cyc;
        logic [6:0] phase;
        logic [19:0] mon_cnt;
        logic mon;
        logic [7:0] lost_cnt;
        bsis_pkg::bsis_uart_t rx_st;
        logic [8:0] rx_cnt;
        logic [2:0] rx_bit;
        logic [7:0] rx_sh;
        logic [7:0] aux_byte;
        logic [31:0] word_sh;
        logic [1:0] word_n;
        logic [11:0] byte_cnt;
        logic [31:0] smp_data;
        logic smp_valid;
        logic smp_second_tick_sample;
        logic [31:0] rd_data;
    } bsis_dev_t;

    bsis_dev_t r;
    bsis_dev_t next_r;

    always_comb
    begin
        logic ref_edge;
        logic second_tick_sample;
        logic alt_rise;
        logic tick_ev;
        logic smp_now;
        logic load_ev;
        logic byte_done;
        logic cfg_bad;
        logic [6:0] kmask;
        logic [31:0] per_sec;
        logic [31:0] packed_bs;
        logic [5:0] w1c;
        logic [5:0] ev;
        int j;
        ref_edge = r.ref_s2 & ~r.ref_s3;
        second_tick_sample = ref_edge & r.tick_s2 & ~r.tick_prev;
        alt_rise = r.alt_s2 & ~r.alt_s3;
        tick_ev = second_tick_sample | alt_rise;
        kmask = 7'((8'h1 << r.rate_k) - 8'h1);
        per_sec = 32'(SECOND_BASE_P) << r.freq;
        packed_bs = 32'h0;
        w1c = 6'h0;
        ev = 6'h0;
        byte_done = 1'b0;
        smp_now = 1'b0;
        load_ev = 1'b0;
        cfg_bad = 1'b0;
        j = 0;
        next_r = r;
        next_r.ref_s1 = link.ref_clk;
        next_r.ref_s2 = r.ref_s1;
        next_r.ref_s3 = r.ref_s2;
        next_r.tick_s1 = link.second_tick;
        next_r.tick_s2 = r.tick_s1;
        next_r.alt_s1 = link.alternate_second_tick;
        next_r.alt_s2 = r.alt_s1;
        next_r.alt_s3 = r.alt_s2;
        next_r.aux_s1 = link.aux_serial_in;
        next_r.aux_s2 = r.aux_s1;
        next_r.bs_s1 = link.input_bit_stream;
        next_r.bs_s2 = r.bs_s1;
        next_r.smp_valid = 1'b0;
        next_r.rd_data = 32'h0;

        // Sample phase and observe time count reference edges, so drift only stretches the second.
        if (ref_edge)
        begin
            next_r.tick_prev = r.tick_s2;
            next_r.phase = second_tick_sample ? 7'h1 : r.phase + 7'h1;
        end
        smp_now = ref_edge & (second_tick_sample | ((r.phase & kmask) == 7'h0));
        for (int i = 0; i < bsis_pkg::NSTREAM; i++)
        begin
            if (r.active[i])
            begin
                packed_bs[j[4:0]] = r.bs_s2[i];
                j = j + 1;
            end
        end
        cfg_bad = !(j inside {1, 2, 4, 8, 16}) || (r.rate_k > r.freq) ||
                  (r.freq > bsis_pkg::FREQ_MAX);
        ev[bsis_pkg::ST_CFG] = cfg_bad;
        if (smp_now)
        begin
            next_r.smp_valid = 1'b1;
            next_r.smp_data = packed_bs;
            next_r.smp_second_tick_sample = second_tick_sample;
        end

        if (register_write_ctrl(wr_en, addr))
        begin
            next_r.freq = wr_data[bsis_pkg::CTRL_FREQ_LSB +: 3];
            next_r.rate_k = wr_data[bsis_pkg::CTRL_RATE_LSB +: 3];
            next_r.use_alt = wr_data[bsis_pkg::CTRL_USE_ALT];
            next_r.auto_upd = wr_data[bsis_pkg::CTRL_AUTO];
            if (wr_data[bsis_pkg::CTRL_ARM])
            begin
                next_r.armed = 1'b1;
            end
        end
        if (wr_en)
        begin
            case (addr)
                bsis_pkg::REG_ACTIVE: next_r.active = wr_data;
                bsis_pkg::REG_SET_SEC: next_r.set_sec = wr_data;
                bsis_pkg::REG_STATUS: w1c = wr_data[5:0];
                bsis_pkg::REG_MASK: next_r.mask = wr_data[5:0];
                default: next_r.mask = next_r.mask;
            endcase
        end

        // A pending alternate tick is used at the next reference edge.
        if (ref_edge)
        begin
            next_r.alt_pend = 1'b0;
        end
        else if (alt_rise)
        begin
            next_r.alt_pend = 1'b1;
        end
        load_ev = r.armed & (r.use_alt ? (ref_edge & (r.alt_pend | alt_rise)) : second_tick_sample);
        if (r.mon_cnt != 20'h0)
        begin
            next_r.mon_cnt = r.mon_cnt - 20'h1;
        end
        if (load_ev)
        begin
            next_r.obs_sec = r.set_sec;
            next_r.obs_cyc = 32'h0;
            next_r.clk_set = 1'b1;
            next_r.armed = 1'b0;
            next_r.mon_cnt = 20'(MON_CYCLES_P);
            ev[bsis_pkg::ST_SET] = 1'b1;
        end
        else if (r.clk_set && ref_edge)
        begin
            // Later ticks are ignored here; only reference cycles advance time.
            if (r.obs_cyc == per_sec - 32'h1)
            begin
                next_r.obs_cyc = 32'h0;
                next_r.obs_sec = r.obs_sec + 32'h1;
                next_r.mon_cnt = 20'(MON_CYCLES_P);
            end
            else
            begin
                next_r.obs_cyc = r.obs_cyc + 32'h1;
            end
        end
        next_r.mon = next_r.mon_cnt != 20'h0;
        ev[bsis_pkg::ST_TICK] = tick_ev;

        // A silent reference clock is flagged so software can reset.
        if (ref_edge)
        begin
            next_r.lost_cnt = 8'h0;
        end
        else if (r.lost_cnt != 8'(bsis_pkg::LOST_CYCLES))
        begin
            next_r.lost_cnt = r.lost_cnt + 8'h1;
            ev[bsis_pkg::ST_LOST] = r.lost_cnt == 8'(bsis_pkg::LOST_CYCLES - 1);
        end

        case (r.rx_st)
            bsis_pkg::UART_IDLE:
            begin
                next_r.rx_cnt = 9'h0;
                if (!r.aux_s2)
                begin
                    next_r.rx_st = bsis_pkg::UART_START;
                end
            end
            bsis_pkg::UART_START:
            begin
                next_r.rx_cnt = r.rx_cnt + 9'h1;
                if (r.rx_cnt == 9'(bsis_pkg::HALF_BIT_CYCLES - 1))
                begin
                    next_r.rx_cnt = 9'h0;
                    next_r.rx_bit = 3'h0;
                    next_r.rx_st = r.aux_s2 ? bsis_pkg::UART_IDLE : bsis_pkg::UART_DATA;
                end
            end
            bsis_pkg::UART_DATA:
            begin
                next_r.rx_cnt = r.rx_cnt + 9'h1;
                if (r.rx_cnt == 9'(bsis_pkg::BIT_CYCLES - 1))
                begin
                    next_r.rx_cnt = 9'h0;
                    next_r.rx_sh = {r.aux_s2, r.rx_sh[7:1]};
                    next_r.rx_bit = r.rx_bit + 3'h1;
                    if (r.rx_bit == 3'h7)
                    begin
                        next_r.rx_st = bsis_pkg::UART_STOP;
                    end
                end
            end
            bsis_pkg::UART_STOP:
            begin
                next_r.rx_cnt = r.rx_cnt + 9'h1;
                if (r.rx_cnt == 9'(bsis_pkg::BIT_CYCLES - 1))
                begin
                    next_r.rx_st = bsis_pkg::UART_IDLE;
                    byte_done = r.aux_s2;
                end
            end
            default:
            begin
                next_r.rx_st = bsis_pkg::UART_IDLE;
            end
        endcase

        if (tick_ev)
        begin
            next_r.byte_cnt = 12'h0;
            next_r.word_n = 2'h0;
        end
        else if (byte_done)
        begin
            next_r.aux_byte = r.rx_sh;
            ev[bsis_pkg::ST_BYTE] = 1'b1;
            next_r.word_sh = {r.word_sh[23:0], r.rx_sh};
            next_r.word_n = r.word_n + 2'h1;
            if (r.byte_cnt == 12'(bsis_pkg::AUX_MAX_BYTES))
            begin
                ev[bsis_pkg::ST_OVF] = 1'b1;
            end
            else
            begin
                next_r.byte_cnt = r.byte_cnt + 12'h1;
            end
            // Four bytes, most significant first, arm a load at the next tick.
            if (r.word_n == 2'h3 && r.auto_upd)
            begin
                next_r.set_sec = {r.word_sh[23:0], r.rx_sh};
                next_r.armed = 1'b1;
            end
        end

        // Soft reset clears the time base after a clock break; it wins over loads.
        if (register_write_ctrl(wr_en, addr) && wr_data[bsis_pkg::CTRL_SOFT_RST])
        begin
            next_r.clk_set = 1'b0;
            next_r.armed = 1'b0;
            next_r.obs_sec = 32'h0;
            next_r.obs_cyc = 32'h0;
            next_r.phase = 7'h0;
            next_r.mon_cnt = 20'h0;
            next_r.mon = 1'b0;
            next_r.byte_cnt = 12'h0;
            next_r.word_n = 2'h0;
        end
        // Events set status in the same cycle as a clear and win.
        next_r.status = (r.status & ~w1c) | ev;

        if (rd_en)
        begin
            case (addr)
                bsis_pkg::REG_CTRL: next_r.rd_data = {22'h0, r.armed, r.clk_set, r.auto_upd,
                                                      r.use_alt, r.rate_k, r.freq};
                bsis_pkg::REG_ACTIVE: next_r.rd_data = r.active;
                bsis_pkg::REG_SET_SEC: next_r.rd_data = r.set_sec;
                bsis_pkg::REG_STATUS: next_r.rd_data = {26'h0, r.status};
                bsis_pkg::REG_MASK: next_r.rd_data = {26'h0, r.mask};
                bsis_pkg::REG_OBS_SEC: next_r.rd_data = r.obs_sec;
                bsis_pkg::REG_OBS_CYC: next_r.rd_data = r.obs_cyc;
                bsis_pkg::REG_AUX_BYTE: next_r.rd_data = {24'h0, r.aux_byte};
                default: next_r.rd_data = 32'h0;
            endcase
        end
    end

    function automatic logic register_write_ctrl(input logic we, input logic [3:0] a);
        register_write_ctrl = we && (a == bsis_pkg::REG_CTRL);
    endfunction

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            r <= '0;
            r.active <= bsis_pkg::ACTIVE_RST;
            // The aux line idles high; starting its synchroniser low would fake a start bit.
            r.aux_s1 <= 1'b1;
            r.aux_s2 <= 1'b1;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign rd_data = r.rd_data;
    assign sample_data = r.smp_data;
    assign sample_valid = r.smp_valid;
    assign sample_second_tick_sample = r.smp_second_tick_sample;
    assign irq = |(r.status & r.mask);
    assign observe_time_monitor = r.mon;
endmodule

// ===== verif/bsis_link_assertions.sv
// Concurrent checks on the link wires and on the sampler's outputs.
`timescale 1ns/1ns
module bsis_link_assertions #(
    parameter int MON_CYCLES_P = bsis_pkg::MON_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ref_clk,
    input wire logic second_tick,
    input wire logic alternate_second_tick,
    input wire logic [31:0] input_bit_stream,
    input wire logic aux_serial_in,
    input wire logic sample_valid,
    input wire logic sample_second_tick_sample,
    input wire logic observe_time_monitor
);
    int mon_len;
    int next_mon_len;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // Counts how long the monitor has been high, since the length is too long to unroll.
    always_comb next_mon_len = observe_time_monitor ? mon_len + 1 : 0;
    always_ff @(posedge clk) mon_len <= srst ? 0 : next_mon_len;
    AST_REF_HALF: assert property ($rose(ref_clk) |-> ref_clk [*4] ##1 !ref_clk)
        else $error("reference clock high time wrong");
    AST_STREAM_ON_FALL: assert property ($changed(input_bit_stream) |-> $fell(ref_clk))
        else $error("streams changed away from a falling reference edge");
    AST_TICK_ON_FALL: assert property ($rose(second_tick) |-> $fell(ref_clk))
        else $error("tick rose away from a falling reference edge");
    AST_TICK_WIDTH: assert property ($rose(second_tick) |-> second_tick [*8] ##1 !second_tick)
        else $error("tick does not last one reference period");
    AST_AUX_LOW: assert property ($fell(aux_serial_in) |-> !aux_serial_in [*8])
        else $error("aux serial low bit too short");
    AST_SECOND_TICK_SAMPLE_FLAG: assert property ($rose(sample_second_tick_sample) |-> sample_valid)
        else $error("tick sample flag without a sample");
    AST_TICK_SAMPLE: assert property ($rose(second_tick) |-> ##[4:12] (sample_valid && sample_second_tick_sample))
        else $error("no tick sample after tick");
    AST_SAMPLE_GAP: assert property (sample_valid |=> !sample_valid [*7])
        else $error("samples closer than one reference period");
    AST_MON_LEN: assert property ($fell(observe_time_monitor) |-> mon_len == MON_CYCLES_P)
        else $error("monitor pulse length wrong");
    COV_SECOND_TICK_SAMPLE: cover property (sample_valid && sample_second_tick_sample);
    COV_MON: cover property ($rose(observe_time_monitor));
    COV_ALT: cover property ($rose(alternate_second_tick));
    COV_AUX: cover property ($fell(aux_serial_in));
endmodule

// ===== verif/tb.sv
// Self-checking bench for the input sampler facing its source end.
`timescale 1ns/1ns
module tb;
    logic clk;
    logic srst;
    logic [3:0] addr;
    logic [31:0] wr_data;
    logic wr_en;
    logic rd_en;
    logic [31:0] rd_data;
    logic [31:0] sample_data;
    logic sample_valid;
    logic sample_second_tick_sample;
    logic irq;
    logic observe_time_monitor;
    logic [31:0] streams_in;
    logic tick_req;
    logic alt_tick_in;
    logic [7:0] tx_data;
    logic tx_valid;
    logic tx_ready;
    int err_total;
    int tests_run;
    int n;
    bsis_link_if link ();
    bsis_acquisition_source bsis_acquisition_source_i (.clk(clk), .srst(srst), .link(link),
        .streams_in(streams_in), .tick_req(tick_req), .alt_tick_in(alt_tick_in),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .data_taken());
    // Short monitor and second counts keep the run brief.
    bsis_acquisition_input_module #(.MON_CYCLES_P(20), .SECOND_BASE_P(16))
        bsis_acquisition_input_module_i (.clk(clk), .srst(srst), .link(link), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .sample_data(sample_data), .sample_valid(sample_valid), .sample_second_tick_sample(sample_second_tick_sample),
        .irq(irq), .observe_time_monitor(observe_time_monitor));
    bsis_link_assertions #(.MON_CYCLES_P(20)) bsis_link_assertions_i (.clk(clk), .srst(srst),
        .ref_clk(link.ref_clk), .second_tick(link.second_tick),
        .alternate_second_tick(link.alternate_second_tick),
        .input_bit_stream(link.input_bit_stream), .aux_serial_in(link.aux_serial_in),
        .sample_valid(sample_valid), .sample_second_tick_sample(sample_second_tick_sample),
        .observe_time_monitor(observe_time_monitor));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] v;
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        v = rd_data;
        @(posedge clk);
        check(v, exp);
    endtask
    task automatic pulse_tick();
        tick_req <= 1'b1;
        @(posedge clk);
        tick_req <= 1'b0;
    endtask
    // Offers one aux byte, waits until the source takes it, then lets an edge pass.
    task automatic send_byte(input logic [7:0] d);
        tx_data <= d;
        tx_valid <= 1'b1;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end while (tx_ready !== 1'b1 && n < 5000);
        check({31'h0, tx_ready}, 32'h1);
        @(posedge clk);
        tx_valid <= 1'b0;
        @(posedge clk);
    endtask
    // Polls on the falling edge so registered outputs have settled.
    task automatic wait_irq();
        n = 0;
        while (irq !== 1'b1 && n < 20000)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= 20000)
        begin
            err_total++;
        end
        @(posedge clk);
    endtask
    task automatic results();
        if (err_total == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial
    begin
        #1000000;
        err_total++;
        results();
    end
    initial
    begin
        srst = 1'b1;
        addr = 4'h0;
        wr_data = 32'h0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        streams_in = 32'ha5a5_5a5a;
        tick_req = 1'b0;
        alt_tick_in = 1'b0;
        tx_data = 8'h00;
        tx_valid = 1'b0;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rchk(bsis_pkg::REG_ACTIVE, bsis_pkg::ACTIVE_RST);
        rchk(bsis_pkg::REG_CTRL, 32'h0);
        rchk(4'hf, 32'h0);
        wr(bsis_pkg::REG_ACTIVE, 32'h0000_00f0);
        for (int k = 0; k < 3; k++)
        begin
            wr(bsis_pkg::REG_CTRL, 32'(k << 3) | 32'h2);
            pulse_tick();
            n = 0;
            do
            begin
                @(negedge clk);
                n++;
            end while (!(sample_valid === 1'b1 && sample_second_tick_sample === 1'b1) && n < 200);
            check({30'h0, sample_valid, sample_second_tick_sample}, 32'h3);
            check(sample_data, 32'h0000_0005);
            n = 0;
            do
            begin
                @(negedge clk);
                n++;
            end while (sample_valid !== 1'b1 && n < 300);
            check(32'(n), 32'(8 << k));
            @(posedge clk);
        end
        // Three active streams is not a legal subset and must be flagged.
        wr(bsis_pkg::REG_ACTIVE, 32'h0000_0007);
        wr(bsis_pkg::REG_STATUS, 32'h3f);
        rchk(bsis_pkg::REG_STATUS, 32'h20);
        wr(bsis_pkg::REG_ACTIVE, 32'h0000_00f0);
        wr(bsis_pkg::REG_STATUS, 32'h3f);
        wr(bsis_pkg::REG_MASK, 32'h2);
        wr(bsis_pkg::REG_SET_SEC, 32'h123);
        wr(bsis_pkg::REG_CTRL, 32'h202);
        pulse_tick();
        wait_irq();
        check({31'h0, observe_time_monitor}, 32'h1);
        rchk(bsis_pkg::REG_STATUS, 32'h3);
        wr(bsis_pkg::REG_STATUS, 32'h2);
        rchk(bsis_pkg::REG_STATUS, 32'h1);
        check({31'h0, irq}, 32'h0);
        rchk(bsis_pkg::REG_CTRL, 32'h102);
        // One second is 64 reference edges here; reading mid-second avoids the boundary.
        repeat (740) @(posedge clk);
        rchk(bsis_pkg::REG_OBS_SEC, 32'h124);
        wr(bsis_pkg::REG_CTRL, 32'h100);
        wr(bsis_pkg::REG_STATUS, 32'h3f);
        wr(bsis_pkg::REG_MASK, 32'h2);
        wr(bsis_pkg::REG_SET_SEC, 32'h77);
        wr(bsis_pkg::REG_CTRL, 32'h242);
        alt_tick_in <= 1'b1;
        repeat (8) @(posedge clk);
        alt_tick_in <= 1'b0;
        wait_irq();
        check({31'h0, irq}, 32'h1);
        rchk(bsis_pkg::REG_OBS_SEC, 32'h77);
        // Let the monitor pulse end first so the soft reset does not cut it short.
        repeat (30) @(posedge clk);
        wr(bsis_pkg::REG_CTRL, 32'h100);
        wr(bsis_pkg::REG_CTRL, 32'h082);
        wr(bsis_pkg::REG_MASK, 32'h4);
        // Four aux bytes, most significant first, carry the second to load.
        for (int b = 3; b >= 0; b--)
        begin
            wr(bsis_pkg::REG_STATUS, 32'h3f);
            send_byte(8'(32'h0000_023c >> (8 * b)));
            wait_irq();
        end
        rchk(bsis_pkg::REG_AUX_BYTE, 32'h3c);
        rchk(bsis_pkg::REG_CTRL, 32'h282);
        rchk(bsis_pkg::REG_SET_SEC, 32'h23c);
        wr(bsis_pkg::REG_STATUS, 32'h3f);
        wr(bsis_pkg::REG_MASK, 32'h2);
        pulse_tick();
        wait_irq();
        rchk(bsis_pkg::REG_OBS_SEC, 32'h23c);
        results();
    end
endmodule
